// *** verilog/lock_pkg.sv ***
// constants and types shared by the protection lock block
package lock_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_KEY0 = 8'h00;
  localparam logic [7:0] OFF_KEY3 = 8'h0C;
  localparam logic [7:0] OFF_CMD = 8'h10;
  localparam logic [7:0] OFF_STATE = 8'h14;
  localparam logic [7:0] OFF_FAR = 8'h18;
  localparam logic [7:0] OFF_FSR = 8'h1C;
  localparam logic [7:0] OFF_FCR = 8'h20;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h24;
  localparam logic [7:0] OFF_IRQ_CLR = 8'h28;
  localparam logic [7:0] OFF_IRQ_EN = 8'h2C;
  localparam logic [7:0] OFF_CFG = 8'h30;
  localparam logic [7:0] OFF_PA_BASE = 8'h40;
  localparam logic [5:0] PA_FIRST_IDX = 6'h10;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CMD_KEY_STATUS_RESET_BIT = 2;
  localparam int CMD_LOCK_BIT = 1;
  localparam int CMD_UNLOCK_BIT = 0;
  localparam int STATE_LK_BIT = 0;
  localparam int FCR_CLR_BIT = 0;
  localparam int FSR_LOCAL_BIT = 8;
  localparam int FSR_SR_BIT = 5;
  localparam int FSR_SW_BIT = 4;
  localparam int FSR_UR_BIT = 2;
  localparam int FSR_UW_BIT = 1;

  // event bits of the interrupt status, enable and clear registers
  localparam int EV_W = 4;
  localparam int EV_SEQ = 0;
  localparam int EV_KEY = 1;
  localparam int EV_PERM = 2;
  localparam int EV_LOCK = 3;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] CFG_RST = 32'h0000_0000;
  localparam logic [31:0] PA_RST = 32'h0000_0000;
  localparam logic [EV_W-1:0] IEN_RST = 4'h0;

  // lock state
  typedef enum logic {
    LK_OPEN = 1'b0,
    LK_SHUT = 1'b1
  } lock_st_t;

endpackage

// *** verilog/protection_lock.sv ***
// protection lock with key sequencing, fault capture and register guard
`timescale 1ns/1ps

module protection_lock #(
  parameter int NPA = 16,
  parameter int KEY_BITS = 128,
  parameter logic [31:0] BASE_ADDR = 32'h0000_0000
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic supervisor,
  output logic lock_engaged,
  output logic exception,
  output logic irq,
  output logic [31:0] prot_config,
  output logic [NPA*32-1:0] page_attr
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  localparam logic [127:0] KEY_MASK = {128{1'b1}} >> (128 - KEY_BITS);
  localparam logic [6:0] NPA7 = 7'(NPA);

  typedef struct packed {
    logic ack;
    logic [31:0] rdat;
    lock_pkg::lock_st_t lk;
    logic seq_open;
    logic [3:0] written;
    logic [127:0] key;
    logic [127:0] wkey;
    logic fvalid;
    logic [31:0] far;
    logic [31:0] fsr;
    logic exc;
    logic [lock_pkg::EV_W-1:0] ist;
    logic [lock_pkg::EV_W-1:0] ien;
    logic [31:0] cfg;
    logic [NPA*32-1:0] pa;
  } state_t;

  state_t s_q;
  state_t s_d;

  logic req;
  logic wr;
  logic rd;
  logic deny;
  logic seq_fault;
  logic key_fault;
  logic [lock_pkg::EV_W-1:0] ev;
  logic [lock_pkg::EV_W-1:0] ev_clr;
  logic [1:0] kidx;
  logic [5:0] pidx;
  logic [31:0] access_type;
  logic full_seq;

  // byte-lane merge of a write into a stored word
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // request decode helpers
  // ----------------------------------------------------------------
  // one wait state: the request is taken on the edge that raises ack
  assign req = wb_cyc_i & wb_stb_i & ~s_q.ack;
  assign wr = req & wb_we_i;
  assign rd = req & ~wb_we_i;
  assign kidx = wb_adr_i[3:2];
  assign pidx = wb_adr_i[7:2] - lock_pkg::PA_FIRST_IDX;
  assign full_seq = s_q.seq_open & (&s_q.written);

  // access type recorded for a refused access, always a local access
  always_comb begin
    access_type = '0;
    access_type[lock_pkg::FSR_LOCAL_BIT] = 1'b1;
    if (supervisor) begin
      access_type[lock_pkg::FSR_SW_BIT] = wb_we_i;
      access_type[lock_pkg::FSR_SR_BIT] = ~wb_we_i;
    end else begin
      access_type[lock_pkg::FSR_UW_BIT] = wb_we_i;
      access_type[lock_pkg::FSR_UR_BIT] = ~wb_we_i;
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.ack = req;
    s_d.exc = 1'b0;
    deny = 1'b0;
    seq_fault = 1'b0;
    key_fault = 1'b0;
    ev = '0;
    ev_clr = '0;
    if (req) begin
      s_d.rdat = '0;
    end

    // address decode, unmapped words answer with zero
    if (wb_adr_i <= lock_pkg::OFF_KEY3) begin
      // key words are write-only and supervisor-only
      if (rd || (wr && !supervisor)) begin
        deny = 1'b1;
      end else if (wr) begin
        if (!s_q.seq_open || s_q.written[kidx]) begin
          seq_fault = 1'b1;
        end else begin
          s_d.wkey[kidx*32 +: 32] = merge(s_q.wkey[kidx*32 +: 32], wb_dat_i, wb_sel_i);
          s_d.written[kidx] = 1'b1;
        end
      end
    end else if (wb_adr_i == lock_pkg::OFF_CMD) begin
      if (rd || (wr && !supervisor)) begin
        deny = 1'b1;
      end else if (wr && wb_sel_i[0]) begin
        if (wb_dat_i[lock_pkg::CMD_KEY_STATUS_RESET_BIT]) begin
          // fresh sequence; a command in the same write sees it empty
          s_d.seq_open = 1'b1;
          s_d.written = '0;
        end
        if (wb_dat_i[lock_pkg::CMD_LOCK_BIT] && wb_dat_i[lock_pkg::CMD_UNLOCK_BIT]) begin
          seq_fault = 1'b1;
        end else if (wb_dat_i[lock_pkg::CMD_LOCK_BIT]) begin
          if (wb_dat_i[lock_pkg::CMD_KEY_STATUS_RESET_BIT] || !full_seq
              || s_q.lk == lock_pkg::LK_SHUT) begin
            seq_fault = 1'b1;
          end else begin
            s_d.lk = lock_pkg::LK_SHUT;
            s_d.key = s_q.wkey & KEY_MASK;
            s_d.seq_open = 1'b0;
            ev[lock_pkg::EV_LOCK] = 1'b1;
          end
        end else if (wb_dat_i[lock_pkg::CMD_UNLOCK_BIT]) begin
          if (wb_dat_i[lock_pkg::CMD_KEY_STATUS_RESET_BIT] || !full_seq
              || s_q.lk == lock_pkg::LK_OPEN) begin
            seq_fault = 1'b1;
          end else if (((s_q.wkey & KEY_MASK) ^ s_q.key) != '0) begin
            key_fault = 1'b1;
            s_d.seq_open = 1'b0;
          end else begin
            s_d.lk = lock_pkg::LK_OPEN;
            s_d.seq_open = 1'b0;
            ev[lock_pkg::EV_LOCK] = 1'b1;
          end
        end
      end
    end else if (wb_adr_i == lock_pkg::OFF_STATE) begin
      if (wr) begin
        deny = 1'b1;
      end else if (rd) begin
        s_d.rdat[lock_pkg::STATE_LK_BIT] = s_q.lk;
      end
    end else if (wb_adr_i == lock_pkg::OFF_FAR) begin
      if (wr) begin
        deny = 1'b1;
      end else if (rd) begin
        s_d.rdat = s_q.far;
      end
    end else if (wb_adr_i == lock_pkg::OFF_FSR) begin
      if (wr) begin
        deny = 1'b1;
      end else if (rd) begin
        s_d.rdat = s_q.fsr;
      end
    end else if (wb_adr_i == lock_pkg::OFF_FCR) begin
      if (rd) begin
        deny = 1'b1;
      end else if (wr && wb_sel_i[0] && wb_dat_i[lock_pkg::FCR_CLR_BIT]) begin
        s_d.fvalid = 1'b0;
        s_d.far = '0;
        s_d.fsr = '0;
      end
    end else if (wb_adr_i == lock_pkg::OFF_IRQ_STAT) begin
      if (rd) begin
        s_d.rdat[lock_pkg::EV_W-1:0] = s_q.ist;
      end
    end else if (wb_adr_i == lock_pkg::OFF_IRQ_CLR) begin
      if (wr && wb_sel_i[0]) begin
        ev_clr = wb_dat_i[lock_pkg::EV_W-1:0];
      end
    end else if (wb_adr_i == lock_pkg::OFF_IRQ_EN) begin
      if (rd) begin
        s_d.rdat[lock_pkg::EV_W-1:0] = s_q.ien;
      end else if (wr && wb_sel_i[0]) begin
        s_d.ien = wb_dat_i[lock_pkg::EV_W-1:0];
      end
    end else if (wb_adr_i == lock_pkg::OFF_CFG) begin
      if (rd) begin
        s_d.rdat = s_q.cfg;
      end else if (wr && (!supervisor || s_q.lk == lock_pkg::LK_SHUT)) begin
        deny = 1'b1;
      end else if (wr) begin
        s_d.cfg = merge(s_q.cfg, wb_dat_i, wb_sel_i);
      end
    end else if (wb_adr_i >= lock_pkg::OFF_PA_BASE && {1'b0, pidx} < NPA7) begin
      if (rd) begin
        s_d.rdat = s_q.pa[pidx*32 +: 32];
      end else if (wr && (!supervisor || s_q.lk == lock_pkg::LK_SHUT)) begin
        deny = 1'b1;
      end else if (wr) begin
        s_d.pa[pidx*32 +: 32] = merge(s_q.pa[pidx*32 +: 32], wb_dat_i, wb_sel_i);
      end
    end

    // a failed sequence must be restarted with a key reset
    if (seq_fault) begin
      s_d.seq_open = 1'b0;
    end

    // events of this request
    ev[lock_pkg::EV_SEQ] = seq_fault;
    ev[lock_pkg::EV_KEY] = key_fault;
    ev[lock_pkg::EV_PERM] = deny;

    // one fault is held; later ones are not recorded until software clears it
    if ((seq_fault || key_fault || deny) && !s_q.fvalid) begin
      s_d.fvalid = 1'b1;
      s_d.far = BASE_ADDR + {24'h00_0000, wb_adr_i};
      s_d.fsr = access_type;
      s_d.exc = 1'b1;
    end

    // set wins over a clear in the same cycle
    s_d.ist = (s_q.ist & ~ev_clr) | ev;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q.ack <= 1'b0;
      s_q.rdat <= '0;
      s_q.lk <= lock_pkg::LK_OPEN;
      s_q.seq_open <= 1'b0;
      s_q.written <= '0;
      s_q.key <= '0;
      s_q.wkey <= '0;
      s_q.fvalid <= 1'b0;
      s_q.far <= '0;
      s_q.fsr <= '0;
      s_q.exc <= 1'b0;
      s_q.ist <= '0;
      s_q.ien <= lock_pkg::IEN_RST;
      s_q.cfg <= lock_pkg::CFG_RST;
      s_q.pa <= {NPA{lock_pkg::PA_RST}};
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign wb_ack_o = s_q.ack;
  assign wb_dat_o = s_q.rdat;
  assign lock_engaged = (s_q.lk == lock_pkg::LK_SHUT);
  assign exception = s_q.exc;
  assign irq = |(s_q.ist & s_q.ien);
  assign prot_config = s_q.cfg;
  assign page_attr = s_q.pa;

endmodule

// *** test/lock_props.sv ***
// port-level assertion checker for the protection lock
`timescale 1ns/1ps

module lock_props #(
  parameter int NPA = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  input wire logic supervisor,
  input wire logic lock_engaged,
  input wire logic exception,
  input wire logic [31:0] prot_config,
  input wire logic [NPA*32-1:0] page_attr
);
  // -------------------------------------------
  // helpers
  // -------------------------------------------
  // supervisor command write taken at this edge
  logic cmd_take;
  assign cmd_take = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && supervisor
    && (wb_adr_i[7:2] == lock_pkg::OFF_CMD[7:2]);

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence taken_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence answer_s;
    wb_ack_o ##1 !wb_ack_o;
  endsequence

  // -------------------------------------------
  // properties
  // -------------------------------------------
  reset_open_a:
    assert property ($fell(rst) |-> !lock_engaged) else $error("locked after reset");
  ack_reply_a:
    assert property (taken_s |=> answer_s) else $error("ack not a single next-cycle pulse");
  lock_cause_a:
    assert property ($rose(lock_engaged) |-> $past(cmd_take && wb_dat_i[lock_pkg::CMD_LOCK_BIT]))
      else $error("lock engaged without lock command");
  unlock_cause_a:
    assert property ($fell(lock_engaged) |-> $past(cmd_take && wb_dat_i[lock_pkg::CMD_UNLOCK_BIT]))
      else $error("lock released without unlock command");
  user_cmd_a:
    assert property (taken_s and !supervisor |=> $stable(lock_engaged))
      else $error("user access changed lock");
  exc_ack_a:
    assert property (exception |-> wb_ack_o) else $error("exception outside ack");
  exc_pulse_a:
    assert property (exception |=> !exception) else $error("exception longer than a cycle");
  cfg_frozen_a:
    assert property (lock_engaged |=> $stable(prot_config)) else $error("config changed locked");
  page_frozen_a:
    assert property (lock_engaged |=> $stable(page_attr)) else $error("page attr changed locked");
endmodule

bind protection_lock lock_props #(.NPA(NPA)) u_lock_props (.clk, .rst, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_ack_o, .supervisor, .lock_engaged, .exception,
  .prot_config, .page_attr);

// *** test/tb.sv ***
// self-checking bench for the protection lock
`timescale 1ns/1ps

module tb;
  localparam logic [127:0] KEY = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0;
  logic supervisor = 1'b0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic lock_engaged;
  logic exception;
  logic irq;
  logic [31:0] prot_config;
  logic [511:0] page_attr;
  logic [31:0] rdat;
  logic exc;
  int mismatches = 0;
  int cmp_count = 0;

  protection_lock u_protection_lock (.clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .supervisor, .lock_engaged, .exception,
    .irq, .prot_config, .page_attr);

  always #25 clk = ~clk;

  // -------------------------------------------
  // bus tasks
  // -------------------------------------------
  // one classic cycle; read data and the exception pulse are taken at the ack edge
  // returns right after that edge, so cyc stays low one cycle before the next request
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, input logic s);
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    supervisor <= s;
    @(posedge clk);
    while (wb_ack_o !== 1'b1) begin
      @(posedge clk);
    end
    rdat = wb_dat_o;
    exc = exception;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask

  // key reset, then the four words out of order
  task automatic keyseq(input logic [127:0] k);
    acc(1'b1, lock_pkg::OFF_CMD, 32'h4, 1'b1);
    for (int i = 0; i < 4; i++) begin
      acc(1'b1, 8'(4 * ((3 * i) % 4)), k[32 * ((3 * i) % 4) +: 32], 1'b1);
    end
  endtask

  task automatic clrf;
    acc(1'b1, lock_pkg::OFF_FCR, 32'h1, 1'b0);
  endtask

  task automatic stop_test;
    $display("mismatches %0d compares %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // -------------------------------------------
  // scenarios
  // -------------------------------------------
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    acc(1'b0, lock_pkg::OFF_STATE, 32'h0, 1'b0);
    chk(rdat, 32'h0);
    acc(1'b1, lock_pkg::OFF_IRQ_EN, 32'h1, 1'b1);
    acc(1'b1, lock_pkg::OFF_CMD, 32'h4, 1'b1);
    acc(1'b1, lock_pkg::OFF_CMD, 32'h2, 1'b1);
    chk(32'(exc), 32'h1);
    chk(32'(lock_engaged), 32'h0);
    clrf;
    keyseq(KEY);
    acc(1'b1, lock_pkg::OFF_CMD, 32'h2, 1'b1);
    acc(1'b0, lock_pkg::OFF_STATE, 32'h0, 1'b0);
    chk(rdat, 32'h1);
    acc(1'b1, lock_pkg::OFF_IRQ_CLR, 32'h1, 1'b1);
    chk(32'(irq), 32'h0);
    // config write refused while locked
    acc(1'b1, lock_pkg::OFF_CFG, 32'hA5, 1'b1);
    chk(32'(exc), 32'h1);
    chk(prot_config, 32'h0);
    // page attribute write refused while locked
    acc(1'b1, lock_pkg::OFF_PA_BASE, 32'h77, 1'b1);
    chk(page_attr[31:0], 32'h0);
    acc(1'b0, lock_pkg::OFF_FSR, 32'h0, 1'b0);
    chk(rdat, 32'h110);
    clrf;
    acc(1'b0, lock_pkg::OFF_FAR, 32'h0, 1'b0);
    chk(rdat, 32'h0);
    // wrong key keeps the lock
    keyseq(~KEY);
    acc(1'b1, lock_pkg::OFF_CMD, 32'h1, 1'b1);
    chk(32'(exc), 32'h1);
    chk(32'(lock_engaged), 32'h1);
    acc(1'b0, lock_pkg::OFF_FAR, 32'h0, 1'b0);
    chk(rdat, 32'(lock_pkg::OFF_CMD));
    clrf;
    keyseq(KEY);
    acc(1'b1, lock_pkg::OFF_CMD, 32'h1, 1'b1);
    chk(32'(lock_engaged), 32'h0);
    // double key write, then a write with no open sequence
    acc(1'b1, lock_pkg::OFF_CMD, 32'h4, 1'b1);
    acc(1'b1, lock_pkg::OFF_KEY3, 32'h1, 1'b1);
    acc(1'b1, lock_pkg::OFF_KEY3, 32'h1, 1'b1);
    chk(32'(irq), 32'h1);
    acc(1'b0, lock_pkg::OFF_FAR, 32'h0, 1'b0);
    chk(rdat, 32'(lock_pkg::OFF_KEY3));
    clrf;
    acc(1'b1, lock_pkg::OFF_KEY0, 32'h1, 1'b1);
    chk(32'(exc), 32'h1);
    clrf;
    acc(1'b1, lock_pkg::OFF_CMD, 32'h0, 1'b1);
    chk(32'(exc), 32'h0);
    // lock and unlock together is a bad sequence; every event bit is pending by now
    acc(1'b1, lock_pkg::OFF_CMD, 32'h3, 1'b1);
    chk(32'(exc), 32'h1);
    acc(1'b0, lock_pkg::OFF_IRQ_STAT, 32'h0, 1'b1);
    chk(rdat, 32'hF);
    acc(1'b1, lock_pkg::OFF_IRQ_CLR, 32'hF, 1'b1);
    acc(1'b0, lock_pkg::OFF_IRQ_STAT, 32'h0, 1'b0);
    chk(rdat, 32'h0);
    chk(32'(irq), 32'h0);
    acc(1'b0, lock_pkg::OFF_IRQ_EN, 32'h0, 1'b0);
    chk(rdat, 32'h1);
    clrf;
    // unlocked: supervisor may write config, user may not
    acc(1'b1, lock_pkg::OFF_CFG, 32'h5A, 1'b1);
    chk(prot_config, 32'h5A);
    acc(1'b1, lock_pkg::OFF_CFG, 32'h33, 1'b0);
    chk(prot_config, 32'h5A);
    acc(1'b0, lock_pkg::OFF_FSR, 32'h0, 1'b1);
    chk(rdat, 32'h102);
    // page attributes: supervisor writes while unlocked, user reads but never writes
    acc(1'b1, lock_pkg::OFF_PA_BASE + 8'h04, 32'hDEAD_BEEF, 1'b1);
    chk(page_attr[63:32], 32'hDEAD_BEEF);
    acc(1'b0, lock_pkg::OFF_PA_BASE + 8'h04, 32'h0, 1'b0);
    chk(rdat, 32'hDEAD_BEEF);
    acc(1'b1, lock_pkg::OFF_PA_BASE + 8'h04, 32'h1, 1'b0);
    chk(page_attr[63:32], 32'hDEAD_BEEF);
    // byte enables merge only the selected lane into the config word
    wb_sel_i <= 4'h2;
    acc(1'b1, lock_pkg::OFF_CFG, 32'hFFFF_FFFF, 1'b1);
    chk(prot_config, 32'h0000_FF5A);
    wb_sel_i <= 4'hF;
    acc(1'b0, 8'hFC, 32'h0, 1'b1);
    chk(rdat, 32'h0);
    // lock again, then reset in mid-run: lock and registers return to reset values
    keyseq(KEY);
    acc(1'b1, lock_pkg::OFF_CMD, 32'h2, 1'b1);
    chk(32'(lock_engaged), 32'h1);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    acc(1'b0, lock_pkg::OFF_STATE, 32'h0, 1'b0);
    chk(rdat, 32'h0);
    chk(32'(lock_engaged), 32'h0);
    chk(prot_config, 32'h0);
    chk(page_attr[63:32], 32'h0);
    stop_test;
  end

  // bench watchdog, far beyond the expected run
  initial begin
    #200_000;
    mismatches++;
    stop_test;
  end
endmodule
